/* core/dcs_pkg.sv */
// Purpose: shared constants for the debugger control and status registers
// Assumes: one system clock, byte-wide host command stream
// Notes: bit positions, command codes and reset values live here only
package dcs_pkg;
   // host command bytes
   localparam logic [7:0] DCS_CMD_RD_STATUS = 8'h02;
   localparam logic [7:0] DCS_CMD_WR_CTRL = 8'h04;
   localparam logic [7:0] DCS_CMD_RD_CTRL = 8'h05;
   // acknowledge character sent on a breakpoint
   localparam logic [7:0] DCS_ACK_BYTE = 8'hff;
   // control register fields
   localparam int DCS_CTL_HALT = 7;
   localparam int DCS_CTL_BREAKPOINT_ALLOW = 6;
   localparam int DCS_CTL_ACKEN = 5;
   localparam int DCS_CTL_SPIN = 4;
   localparam int DCS_CTL_RSV_HI = 3;
   localparam int DCS_CTL_RSV_LO = 1;
   localparam int DCS_CTL_RST = 0;
   localparam logic [7:0] DCS_CTL_RESET = 8'h00;
   localparam logic [7:0] DCS_CTL_WMASK = 8'hf1;
   // status register fields
   localparam int DCS_ST_IDLE = 7;
   localparam int DCS_ST_HALT = 6;
   localparam int DCS_ST_READ_PROTECT_FLAG = 5;
   localparam logic [4:0] DCS_ST_RSV = 5'h00;
   localparam logic [7:0] DCS_ST_RESET = 8'h00;
   // control patterns named by their function
   localparam logic [7:0] DCS_PAT_RESET_STOP = 8'h81;
   localparam logic [7:0] DCS_PAT_RESET_GO = 8'h41;
   localparam logic [7:0] DCS_PAT_RUN = 8'h40;
   // command parser states
   typedef enum logic {
      DCS_ST_CMD,
      DCS_ST_WDATA
   } dcs_parse_type;
endpackage : dcs_pkg

/* core/dcs_tx_if.sv */
// Purpose: carries one reply byte from the register core to the reply slot
// Assumes: load is only raised while free is high
// Notes: core drives load and data, slot answers with free
`timescale 1ns/10ps
interface dcs_tx_if;
   logic load;
   logic [7:0] data;
   logic free;
   modport core (
      output load,
      output data,
      input free
   );
   modport slot (
      input load,
      input data,
      output free
   );
endinterface : dcs_tx_if

/* core/dcs_sticky.sv */
// Purpose: sticky event flag with set winning over clear
// Assumes: set and clear are single-cycle strobes
// Notes: used for breakpoint-seen and acknowledge-pending
`timescale 1ns/10ps
module dcs_sticky (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // events
   input wire logic set_i,
   input wire logic clr_i,
   // flag
   output logic flag_o
);
   logic flag_reg;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         flag_reg <= 1'b0;
      end else if (set_i) begin
         flag_reg <= 1'b1;
      end else if (clr_i) begin
         flag_reg <= 1'b0;
      end
   end

   assign flag_o = flag_reg;
endmodule : dcs_sticky

/* core/dcs_tx_slot.sv */
// Purpose: one-byte reply holder towards the serial debug link
// Assumes: link takes a byte when valid and ready are both high
// Notes: free only when empty, so a reply never overwrites another
`timescale 1ns/10ps
module dcs_tx_slot (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // core side
   dcs_tx_if.slot tx,
   // link side
   output logic tx_valid_o,
   output logic [7:0] tx_byte_o,
   input wire logic tx_ready_i
);
   logic full_reg;
   logic [7:0] byte_reg;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         full_reg <= 1'b0;
      end else if (tx.load) begin
         full_reg <= 1'b1;
      end else if (tx_ready_i) begin
         full_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         byte_reg <= 8'h00;
      end else if (tx.load) begin
         byte_reg <= tx.data;
      end
   end

   assign tx.free = !full_reg;
   assign tx_valid_o = full_reg;
   assign tx_byte_o = byte_reg;
endmodule : dcs_tx_slot

/* core/dcs_regs.sv */
// Purpose: debugger control and status registers behind host commands
// Assumes: host bytes arrive as one-cycle strobes; debugger reset is rst_n_i
// Notes: other debugger commands are ignored byte by byte
//
// Functional notes
// - writing 81h resets chip, stays halted
// - writing 41h resets chip, runs normally
// - writing 40h in debug mode resumes
// - debug bit set stops instruction fetch
// - clearing debug bit resumes execution
// - enabled non-spin breakpoint sets debug bit
// - read protect blocks clearing debug bit
// - breakpoints off by default, act as nop
// - ack enabled sends ffh on breakpoint
// - spin bit loops on breakpoint instead
// - reset bit resets chip, keeps debugger
// - reset bit self-clears when reset done
// - idle reads debug mode or breakpoint seen
// - halt status mirrors low-power halt mode
// - read-protect status is inverted option bit
// - command 04h loads next byte into control
// - command 05h returns control byte
// - command 02h returns status byte
`timescale 1ns/10ps
module dcs_regs
   import dcs_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // host command bytes
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_byte_i,
   // host reply bytes
   output logic tx_valid_o,
   output logic [7:0] tx_byte_o,
   input wire logic tx_ready_i,
   // cpu and system
   input wire logic brk_decode_i,
   input wire logic halt_mode_i,
   input wire logic rp_option_bit_i,
   input wire logic reset_done_i,
   output logic cpu_stop_o,
   output logic brk_nop_o,
   output logic brk_spin_o,
   output logic sys_reset_o,
   output logic [7:0] ctl_o,
   output logic [7:0] status_o
);
   dcs_tx_if tx_bus ();

   dcs_parse_type parse_reg;
   dcs_parse_type parse_next;
   logic [7:0] ctl_reg;
   logic [7:0] ctl_next;
   logic [7:0] status_now;
   logic rd_pend_reg;
   logic rd_sel_status_reg;
   logic wr_strobe;
   logic rd_ctl_cmd;
   logic rd_st_cmd;
   logic brk_event;
   logic brk_seen;
   logic ack_pend;
   logic ack_issue;
   logic rd_issue;
   logic rp_on;

   assign rp_on = !rp_option_bit_i;
   assign brk_event = brk_decode_i && ctl_reg[DCS_CTL_BREAKPOINT_ALLOW];

   // command parser
   assign wr_strobe = rx_valid_i && (parse_reg == DCS_ST_WDATA);
   assign rd_ctl_cmd = rx_valid_i && (parse_reg == DCS_ST_CMD)
      && (rx_byte_i == DCS_CMD_RD_CTRL);
   assign rd_st_cmd = rx_valid_i && (parse_reg == DCS_ST_CMD)
      && (rx_byte_i == DCS_CMD_RD_STATUS);

   always_comb begin
      parse_next = parse_reg;
      case (parse_reg)
         DCS_ST_CMD: begin
            if (rx_valid_i && rx_byte_i == DCS_CMD_WR_CTRL) begin
               parse_next = DCS_ST_WDATA;
            end
         end
         DCS_ST_WDATA: begin
            if (rx_valid_i) begin
               parse_next = DCS_ST_CMD;
            end
         end
         default: begin
            parse_next = DCS_ST_CMD;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         parse_reg <= DCS_ST_CMD;
      end else begin
         parse_reg <= parse_next;
      end
   end

   // control register next value
   always_comb begin
      ctl_next = ctl_reg;
      if (reset_done_i) begin
         ctl_next[DCS_CTL_RST] = 1'b0;
      end
      if (wr_strobe) begin
         ctl_next = rx_byte_i & DCS_CTL_WMASK;
         if (rp_on && ctl_reg[DCS_CTL_HALT]) begin
            ctl_next[DCS_CTL_HALT] = 1'b1;
         end
      end
      if (brk_event && !ctl_reg[DCS_CTL_SPIN]) begin
         ctl_next[DCS_CTL_HALT] = 1'b1;
      end
   end

   // debugger state survives the system reset it requests
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ctl_reg <= DCS_CTL_RESET;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   // cpu and system controls
   assign cpu_stop_o = ctl_reg[DCS_CTL_HALT];
   assign brk_nop_o = !ctl_reg[DCS_CTL_BREAKPOINT_ALLOW];
   assign brk_spin_o = ctl_reg[DCS_CTL_BREAKPOINT_ALLOW] && ctl_reg[DCS_CTL_SPIN];
   assign sys_reset_o = ctl_reg[DCS_CTL_RST];
   assign ctl_o = ctl_reg;

   // breakpoint seen since last control write
   dcs_sticky u_brk_seen (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .set_i(brk_event),
      .clr_i(wr_strobe),
      .flag_o(brk_seen)
   );

   // status register view
   always_comb begin
      status_now = DCS_ST_RESET;
      status_now[DCS_ST_IDLE] = ctl_reg[DCS_CTL_HALT] || brk_seen;
      status_now[DCS_ST_HALT] = halt_mode_i;
      status_now[DCS_ST_READ_PROTECT_FLAG] = rp_on;
      status_now[4:0] = DCS_ST_RSV;
   end
   assign status_o = status_now;

   // acknowledge pending
   dcs_sticky u_ack_pend (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .set_i(brk_event && ctl_reg[DCS_CTL_ACKEN]),
      .clr_i(ack_issue),
      .flag_o(ack_pend)
   );

   // read reply pending
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rd_pend_reg <= 1'b0;
      end else if (rd_ctl_cmd || rd_st_cmd) begin
         rd_pend_reg <= 1'b1;
      end else if (rd_issue) begin
         rd_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rd_sel_status_reg <= 1'b0;
      end else if (rd_ctl_cmd || rd_st_cmd) begin
         rd_sel_status_reg <= rd_st_cmd;
      end
   end

   // reply arbitration, acknowledge first
   assign ack_issue = tx_bus.free && ack_pend;
   assign rd_issue = tx_bus.free && !ack_pend && rd_pend_reg;
   assign tx_bus.load = ack_issue || rd_issue;

   always_comb begin
      if (ack_issue) begin
         tx_bus.data = DCS_ACK_BYTE;
      end else if (rd_sel_status_reg) begin
         tx_bus.data = status_now;
      end else begin
         tx_bus.data = ctl_reg;
      end
   end

   dcs_tx_slot u_tx_slot (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .tx(tx_bus.slot),
      .tx_valid_o(tx_valid_o),
      .tx_byte_o(tx_byte_o),
      .tx_ready_i(tx_ready_i)
   );

   // checks
   a_reset_stop_write: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_strobe && rx_byte_i == DCS_PAT_RESET_STOP
      |=> cpu_stop_o && sys_reset_o)
      else $error("reset and stop did not halt with reset");

   a_reset_go_write: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_strobe && rx_byte_i == DCS_PAT_RESET_GO && !ctl_reg[DCS_CTL_HALT] && !brk_event
      |=> ctl_reg == DCS_PAT_RESET_GO && !cpu_stop_o)
      else $error("reset and go did not run");

   a_run_resume_write: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_strobe && rx_byte_i == DCS_PAT_RUN && cpu_stop_o && !rp_on && !brk_event
      |=> !cpu_stop_o ##0 brk_nop_o == 1'b0)
      else $error("run write did not resume");

   a_debug_stop_fetch: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_strobe && rx_byte_i[DCS_CTL_HALT] |=> cpu_stop_o && status_o[DCS_ST_IDLE])
      else $error("debug mode without stop and idle");

   a_brk_halt_entry: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      brk_decode_i && ctl_reg[DCS_CTL_BREAKPOINT_ALLOW] && !ctl_reg[DCS_CTL_SPIN]
      |=> cpu_stop_o)
      else $error("breakpoint did not enter debug mode");

   a_rp_hold_halt: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      rp_on && cpu_stop_o |=> cpu_stop_o)
      else $error("debug mode cleared under read protect");

   a_brk_nop_off: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      brk_decode_i && brk_nop_o && !cpu_stop_o && !wr_strobe
      |=> !cpu_stop_o && !$rose(status_o[DCS_ST_IDLE]))
      else $error("disabled breakpoint had an effect");

   a_ack_byte_sent: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      brk_event && ctl_reg[DCS_CTL_ACKEN] && tx_bus.free && !ack_pend && !tx_bus.load
      |=> ##1 tx_valid_o && tx_byte_o == DCS_ACK_BYTE)
      else $error("acknowledge byte not sent");

   a_spin_no_halt: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      brk_event && brk_spin_o && !cpu_stop_o && !wr_strobe
      |=> !cpu_stop_o && status_o[DCS_ST_IDLE])
      else $error("spin breakpoint entered debug mode");

   a_rst_self_clear: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      reset_done_i && !wr_strobe |=> !sys_reset_o)
      else $error("reset bit not cleared");

   a_status_bits_live: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      status_o[DCS_ST_HALT] == halt_mode_i)
      else $error("halt status wrong");

   a_protect_status_live: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      status_o[DCS_ST_READ_PROTECT_FLAG] == !rp_option_bit_i)
      else $error("read protect status wrong");

   a_wr_ctl_load: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_strobe && !brk_event
      |=> ctl_reg[DCS_CTL_BREAKPOINT_ALLOW:DCS_CTL_SPIN] == $past(rx_byte_i[DCS_CTL_BREAKPOINT_ALLOW:DCS_CTL_SPIN]))
      else $error("control write not loaded");

   a_read_reply: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      rd_issue |=> tx_valid_o
         && tx_byte_o == ($past(rd_sel_status_reg) ? $past(status_o) : $past(ctl_o)))
      else $error("read reply byte wrong");

   a_rsvd_read_zero: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      ctl_reg[DCS_CTL_RSV_HI:DCS_CTL_RSV_LO] == 3'h0 && status_o[4:0] == DCS_ST_RSV)
      else $error("reserved bits not zero");

   a_clear_resumes: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_strobe && !rx_byte_i[DCS_CTL_HALT] && !(rp_on && cpu_stop_o) && !brk_event
      |=> !cpu_stop_o)
      else $error("debug mode not left on clear");

   a_sys_reset_req: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_strobe && rx_byte_i[DCS_CTL_RST] |=> sys_reset_o)
      else $error("reset bit write did not request reset");

   a_idle_set_brk: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      brk_event |=> status_o[DCS_ST_IDLE])
      else $error("breakpoint did not set idle");

   a_idle_clear_wr: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_strobe && !rx_byte_i[DCS_CTL_HALT] && !(rp_on && cpu_stop_o) && !brk_event
      |=> !status_o[DCS_ST_IDLE])
      else $error("idle not cleared by control write");

   a_ctrl_read_reply: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      rd_ctl_cmd && !tx_valid_o && !ack_pend && !rd_pend_reg && !brk_event
      |=> ##1 tx_valid_o && tx_byte_o == $past(ctl_o))
      else $error("control read reply wrong");

   a_status_read_reply: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      rd_st_cmd && !tx_valid_o && !ack_pend && !rd_pend_reg && !brk_event
      |=> ##1 tx_valid_o && tx_byte_o == $past(status_o))
      else $error("status read reply wrong");

   a_ack_first: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      ack_pend && rd_pend_reg && tx_bus.free |=> tx_valid_o && tx_byte_o == DCS_ACK_BYTE)
      else $error("read reply sent before acknowledge");

   a_spin_output: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_strobe && rx_byte_i[DCS_CTL_BREAKPOINT_ALLOW] && rx_byte_i[DCS_CTL_SPIN] |=> brk_spin_o)
      else $error("spin write did not enable spin");

   a_nop_write: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_strobe && !rx_byte_i[DCS_CTL_BREAKPOINT_ALLOW] |=> brk_nop_o)
      else $error("breakpoint not disabled by write");
endmodule : dcs_regs

/* sim/dcs_host_model.sv */
// Purpose: debug host model sending command bytes and taking reply bytes
// Assumes: one byte a cycle at most, lines driven at the falling edge
// Notes: a released byte line shows the inverse of the last byte
`timescale 1ns/10ps
module dcs_host_model
   import dcs_pkg::*;
(
   // clock
   input wire logic ref_clk_i,
   // command bytes
   output logic rx_valid_o,
   output logic [7:0] rx_byte_o,
   // reply bytes
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_byte_i,
   output logic tx_ready_o
);
   initial begin
      rx_valid_o = 1'b0;
      rx_byte_o = 8'h5a;
      tx_ready_o = 1'b0;
   end
   task send(input logic [7:0] b);
      @(negedge ref_clk_i);
      rx_valid_o = 1'b1;
      rx_byte_o = b;
   endtask : send
   task release_bus;
      @(negedge ref_clk_i);
      rx_valid_o = 1'b0;
      rx_byte_o = ~rx_byte_o;
   endtask : release_bus
   // take one reply byte, ready raised only after the stall
   task get_reply(input int stall, output logic [7:0] b, output logic ok);
      int n;
      ok = 1'b0;
      b = 8'h00;
      repeat (stall) @(negedge ref_clk_i);
      for (n = 0; n < 40 && !ok; n++) begin
         if (tx_valid_i === 1'b1) begin
            tx_ready_o = 1'b1;
            @(posedge ref_clk_i);
            b = tx_byte_i;
            ok = 1'b1;
         end
         @(negedge ref_clk_i);
      end
      tx_ready_o = 1'b0;
   endtask : get_reply
   // command then exactly one data byte
   task write_ctl(input logic [7:0] d);
      send(DCS_CMD_WR_CTRL);
      send(d);
      release_bus();
   endtask : write_ctl
   // one command byte, one reply byte; status is never written
   task read_cmd(input logic [7:0] c, input int stall, output logic [7:0] b, output logic ok);
      send(c);
      release_bus();
      get_reply(stall, b, ok);
   endtask : read_cmd
endmodule : dcs_host_model

/* sim/test_debug_control_status_regs.sv */
// Purpose: self-checking bench for the debugger control and status registers
// Assumes: host model drives the command stream, bench drives cpu side
// Notes: ends through complete_run, also on the cycle ceiling
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_debug_control_status_regs;
   import dcs_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic breakpoint_opcode = 1'b0;
   logic halt = 1'b0;
   logic rp = 1'b1;
   logic done = 1'b0;
   logic rx_valid, tx_valid, tx_ready, stop, nop, spin, sysrst, ok;
   logic [7:0] rx_byte, tx_byte, ctl, status, b;
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;
   always #20 ref_clk_i = ~ref_clk_i;
   dcs_host_model host (.ref_clk_i(ref_clk_i), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte),
      .tx_valid_i(tx_valid), .tx_byte_i(tx_byte), .tx_ready_o(tx_ready));
   dcs_regs DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .rx_valid_i(rx_valid),
      .rx_byte_i(rx_byte), .tx_valid_o(tx_valid), .tx_byte_o(tx_byte), .tx_ready_i(tx_ready),
      .brk_decode_i(breakpoint_opcode), .halt_mode_i(halt), .rp_option_bit_i(rp), .reset_done_i(done),
      .cpu_stop_o(stop), .brk_nop_o(nop), .brk_spin_o(spin), .sys_reset_o(sysrst),
      .ctl_o(ctl), .status_o(status));
   task complete_run;
      if (n_errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : complete_run
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         complete_run();
      end
   end
   task wr(input logic [7:0] d);
      host.write_ctl(d);
      @(negedge ref_clk_i);
   endtask : wr
   task rd(input logic [7:0] c, input logic [7:0] e, input int stall);
      host.read_cmd(c, stall, b, ok);
      `CHK("reply_ok", 1'b1, ok)
      `CHK("reply", e, b)
   endtask : rd
   task automatic pulse(ref logic s);
      @(negedge ref_clk_i);
      s = 1'b1;
      @(negedge ref_clk_i);
      s = 1'b0;
      @(negedge ref_clk_i);
   endtask : pulse
   initial begin
      repeat (12) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      @(negedge ref_clk_i);
      `CHK("ctl", DCS_CTL_RESET, ctl)
      `CHK("nop", 1'b1, nop)
      `CHK("stop", 1'b0, stop)
      rd(DCS_CMD_RD_CTRL, 8'h00, 0);
      rd(DCS_CMD_RD_STATUS, DCS_ST_RESET, 2);
      wr(8'h4e);
      `CHK("ctl", 8'h40, ctl)
      wr(8'h80);
      `CHK("stop", 1'b1, stop)
      `CHK("idle", 1'b1, status[DCS_ST_IDLE])
      wr(DCS_PAT_RUN);
      `CHK("stop", 1'b0, stop)
      `CHK("status", 8'h00, status)
      pulse(breakpoint_opcode);
      `CHK("stop", 1'b1, stop)
      rd(DCS_CMD_RD_CTRL, 8'hc0, 1);
      wr(8'h50);
      `CHK("spin", 1'b1, spin)
      pulse(breakpoint_opcode);
      `CHK("stop", 1'b0, stop)
      `CHK("idle", 1'b1, status[DCS_ST_IDLE])
      wr(8'h00);
      pulse(breakpoint_opcode);
      `CHK("status", 8'h00, status)
      `CHK("nop", 1'b1, nop)
      wr(DCS_PAT_RESET_STOP);
      `CHK("sysrst", 1'b1, sysrst)
      `CHK("stop", 1'b1, stop)
      pulse(done);
      `CHK("sysrst", 1'b0, sysrst)
      rd(DCS_CMD_RD_CTRL, 8'h80, 0);
      wr(DCS_PAT_RESET_GO);
      `CHK("sysrst", 1'b1, sysrst)
      `CHK("stop", 1'b0, stop)
      pulse(done);
      `CHK("ctl", 8'h40, ctl)
      wr(8'h60);
      host.send(DCS_CMD_RD_CTRL);
      host.release_bus();
      pulse(breakpoint_opcode);
      rd(DCS_CMD_RD_STATUS, 8'h60, 1);
      host.get_reply(3, b, ok);
      `CHK("ack", DCS_ACK_BYTE, b)
      host.get_reply(0, b, ok);
      `CHK("status_reply", 8'h80, b)
      `CHK("stop", 1'b1, stop)
      rp = 1'b0;
      halt = 1'b1;
      @(negedge ref_clk_i);
      rd(DCS_CMD_RD_STATUS, 8'he0, 0);
      `CHK("read_protect_flag", 1'b1, status[DCS_ST_READ_PROTECT_FLAG])
      wr(DCS_PAT_RUN);
      `CHK("ctl", 8'hc0, ctl)
      rst_n_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      @(negedge ref_clk_i);
      `CHK("ctl", 8'h00, ctl)
      complete_run();
   end
endmodule : test_debug_control_status_regs
